// file: pm_phy_pkg.sv
package pm_phy_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  PMCS_OFFSET     = 8'h48;
  localparam logic [7:0]  PMEXT_OFFSET    = 8'h4A;
  localparam logic [7:0]  PHYCTL_OFFSET   = 8'hEC;
  localparam logic [7:0]  HCTL_OFFSET     = 8'h00;
  localparam logic [7:0]  HSTAT_OFFSET    = 8'h04;

  // power-management control and status fields
  localparam int          WAKE_FLAG_BIT   = 15;
  localparam int          WAKE_EN_BIT     = 8;
  localparam logic [1:0]  PWR_D0          = 2'h0;
  localparam logic [1:0]  PWR_D1          = 2'h1;
  localparam logic [1:0]  PWR_D2          = 2'h2;
  localparam logic [1:0]  PWR_D3          = 2'h3;

  // phy side control fields
  localparam int          CNA_ROUTE_BIT   = 7;
  localparam int          PHY_RST_BIT     = 4;
  localparam int          COMPLY_BIT      = 3;
  localparam int          SLEEP_BIT       = 2;
  localparam logic [7:0]  PHYCTL_WMASK    = 8'h9F;
  localparam logic [7:0]  PHYCTL_RESET    = 8'h08;
  localparam logic [15:0] PMCS_RESET      = 16'h0000;

  // host-side controller register bits
  localparam int          HC_GO_BIT       = 0;
  localparam int          HC_WRITE_BIT    = 1;
  localparam int          HC_ADDR_LSB     = 8;
  localparam int          HC_DATA_LSB     = 16;

endpackage : pm_phy_pkg

// file: pm_phy_if.sv
// configuration access path between host and device
interface pm_phy_if;
  logic        cfg_req;
  logic        cfg_write;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_rdata;
  logic        cfg_ack;

  modport device_mp (input cfg_req, cfg_write, cfg_addr, cfg_wdata, cfg_be, output cfg_rdata, cfg_ack);
  modport host_mp   (output cfg_req, cfg_write, cfg_addr, cfg_wdata, cfg_be, input cfg_rdata, cfg_ack);
endinterface : pm_phy_if

// file: pm_phy_regs.sv
module pm_phy_regs
  import pm_phy_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  input  wire logic   global_hard_reset_n_in,
  input  wire logic   d3hot_reset_in,
  input  wire logic   cold_wake_support_in,
  input  wire logic   wake_event_in,
  input  wire logic   cable_not_active_signal_in,
  input  wire logic   eeprom_load_in,
  input  wire logic [7:0] eeprom_data_in,
  pm_phy_if.device_mp cfg,
  output logic        wake_event_n_out,
  output logic        cable_activity_out,
  output logic        physical_layer_reset_out,
  output logic        phy_sleep_control_out,
  output logic [1:0]  power_level_out
);
  import pm_phy_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic       wake_flag;
    logic       wake_en;
    logic [1:0] pwr;
    logic       pme_drive;
    logic [7:0] phyctl;
    logic [31:0] rdata;
    logic       ack;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic wr_hit;
  logic pm_wr;
  logic phy_wr;

  // bus decode; cfg_ack is a one-cycle pulse on the cycle after a request
  assign wr_hit = cfg.cfg_req && cfg.cfg_write && !s_q.ack;
  assign pm_wr  = wr_hit && (cfg.cfg_addr == PMCS_OFFSET);
  assign phy_wr = wr_hit && (cfg.cfg_addr == PHYCTL_OFFSET) && cfg.cfg_be[0];

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d     = s_q;
    s_d.ack = cfg.cfg_req && !s_q.ack;
    // write of 1 clears flag and drops the event line
    if (pm_wr && cfg.cfg_be[1] && cfg.cfg_wdata[WAKE_FLAG_BIT])
    begin
      s_d.wake_flag = 1'b0;
      s_d.pme_drive = 1'b0;
    end
    // set wins over a same-cycle clear
    if (wake_event_in)
    begin
      s_d.wake_flag = 1'b1;
      s_d.pme_drive = 1'b1;
    end
    if (pm_wr && cfg.cfg_be[1])
      s_d.wake_en = cfg.cfg_wdata[WAKE_EN_BIT];
    if (pm_wr && cfg.cfg_be[0])
      s_d.pwr = cfg.cfg_wdata[1:0];
    // only writable bits stored; 6-5 stay zero
    if (phy_wr)
      s_d.phyctl = cfg.cfg_wdata[7:0] & PHYCTL_WMASK;
    if (eeprom_load_in)
      s_d.phyctl = eeprom_data_in & PHYCTL_WMASK;
    // function or D3hot reset: only the non-sticky enable clears
    if ((!rst_n_in || d3hot_reset_in) && !cold_wake_support_in)
      s_d.wake_en = 1'b0;
    // read mux; reserved fields zero
    s_d.rdata = 32'h0000_0000;
    case (cfg.cfg_addr)
      PMCS_OFFSET:   s_d.rdata[15:0] = {s_q.wake_flag, 6'h00, s_q.wake_en, 6'h00, s_q.pwr};
      PMEXT_OFFSET:  s_d.rdata = 32'h0000_0000;
      PHYCTL_OFFSET: s_d.rdata[7:0] = {s_q.phyctl[7:2], 2'h0};
      default:       s_d.rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // only the hard reset clears sticky bits
  always_ff @(posedge clk_in)
  begin
    if (!global_hard_reset_n_in)
    begin
      s_q           <= '0;
      s_q.phyctl    <= PHYCTL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // event pin active low, gated by enable
  assign wake_event_n_out         = !(s_q.pme_drive && s_q.wake_en);
  assign cable_activity_out       = s_q.phyctl[CNA_ROUTE_BIT] && cable_not_active_signal_in;
  assign physical_layer_reset_out = s_q.phyctl[PHY_RST_BIT];
  assign phy_sleep_control_out    = s_q.phyctl[SLEEP_BIT];
  assign power_level_out          = s_q.pwr;
  assign cfg.cfg_rdata            = s_q.rdata;
  assign cfg.cfg_ack              = s_q.ack;

endmodule // pm_phy_regs

// file: pm_phy_host.sv
// host end: Avalon-MM slave with a command register; runs one config access
module pm_phy_host
  import pm_phy_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  pm_phy_if.host_mp        cfg
);
  import pm_phy_pkg::*;

  typedef enum logic [1:0] {IDLE = 2'b00, BUSY = 2'b01, DONE = 2'b10} host_e;

  typedef struct packed {
    host_e       st;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] result;
    logic [31:0] rd;
    logic        rd_ok;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ****************************************
  // next state
  // ****************************************
  // software must pulse phy reset after clearing sleep; not enforced
  always_comb
  begin
    s_d       = s_q;
    s_d.rd_ok = 1'b0;
    if (avs_read_in && !s_q.rd_ok)
    begin
      s_d.rd_ok = 1'b1;
      s_d.rd    = (avs_address_in == HSTAT_OFFSET) ? s_q.result
                  : {30'h0, s_q.st == BUSY, s_q.st == DONE};
    end
    case (s_q.st)
      IDLE, DONE:
      begin
        if (avs_write_in && avs_address_in == HCTL_OFFSET && avs_writedata_in[HC_GO_BIT])
        begin
          s_d.st    = BUSY;
          s_d.wr    = avs_writedata_in[HC_WRITE_BIT];
          s_d.addr  = avs_writedata_in[HC_ADDR_LSB +: 8];
          s_d.wdata = {16'h0, avs_writedata_in[HC_DATA_LSB +: 16]};
        end
      end
      BUSY:
      begin
        if (cfg.cfg_ack)
        begin
          s_d.st     = DONE;
          s_d.result = cfg.cfg_rdata;
        end
      end
      default: s_d.st = IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_waitrequest_out = avs_read_in && !s_q.rd_ok;
  assign avs_readdata_out    = s_q.rd;
  assign cfg.cfg_req         = (s_q.st == BUSY) && !cfg.cfg_ack;
  assign cfg.cfg_write       = s_q.wr;
  assign cfg.cfg_addr        = s_q.addr;
  assign cfg.cfg_wdata       = s_q.wdata;
  assign cfg.cfg_be          = 4'hF;

endmodule // pm_phy_host

// file: pm_phy_monitor.sv
// ****
// wire checks on the config link and the device output pins
// ****
module pm_phy_monitor
  import pm_phy_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        global_hard_reset_n_in,
  input wire logic        cfg_req,
  input wire logic        cfg_write,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_ack,
  input wire logic        wake_event_n_out,
  input wire logic        cable_activity_out,
  input wire logic        cable_not_active_signal_in,
  input wire logic        physical_layer_reset_out,
  input wire logic        phy_sleep_control_out,
  input wire logic [1:0]  power_level_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!global_hard_reset_n_in);
  logic rd_pm;
  logic rd_ext;
  logic rd_phy;
  // reads in flight, by target
  assign rd_pm = cfg_req && !cfg_write && cfg_addr == PMCS_OFFSET;
  assign rd_ext = cfg_req && !cfg_write && cfg_addr == PMEXT_OFFSET;
  assign rd_phy = cfg_req && !cfg_write && cfg_addr == PHYCTL_OFFSET;
  ack_follows_a: assert property ($rose(cfg_req) |=> cfg_ack) else $error("no ack after request");
  ack_single_a: assert property (cfg_ack |=> !cfg_ack) else $error("ack longer than one cycle");
  pm_fields_a: assert property (cfg_ack && $past(rd_pm) |-> cfg_rdata[14:9] == 6'h0 && cfg_rdata[7:2] == 6'h0
    && cfg_rdata[1:0] == power_level_out) else $error("bad power readback");
  ext_zero_a: assert property (cfg_ack && $past(rd_ext) |-> cfg_rdata[15:0] == 16'h0) else $error("extension not 0");
  phy_fields_a: assert property (cfg_ack && $past(rd_phy) |-> cfg_rdata[31:8] == 24'h0 && cfg_rdata[6:5] == 2'h0
    && cfg_rdata[1:0] == 2'h0 && cfg_rdata[4] == physical_layer_reset_out
    && cfg_rdata[2] == phy_sleep_control_out) else $error("bad phy readback");
  event_gate_a: assert property (cfg_ack && $past(rd_pm) && !cfg_rdata[8] |-> wake_event_n_out) else $error("event while off");
  cable_gate_a: assert property (!cable_not_active_signal_in |-> !cable_activity_out) else $error("cable out stray");
  hard_clear_a: assert property (@(posedge clk_in) disable iff (1'h0) !global_hard_reset_n_in |=>
    power_level_out == 2'h0 && !physical_layer_reset_out && !phy_sleep_control_out && wake_event_n_out) else $error("hard reset");
endmodule // pm_phy_monitor

// file: pci_pm_and_phy_control_regs_tb_top.sv
module pci_pm_and_phy_control_regs_tb_top;
  import pm_phy_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_n = 0, global_hard_reset_n = 0, d3 = 0, cold = 0, ev = 0, cable_not_active_signal = 0, ld = 0, av_rd = 0, av_wr = 0;
  logic [7:0] ed = 0, av_a = 0;
  logic [31:0] av_d = 0, rdata, rd, exp_q[$];
  logic wreq, ev_n, cab, prst, psl;
  logic [1:0] pl;
  int errors = 0, checks = 0, s;
  pm_phy_if link();
  always #2 clk_in = ~clk_in;
  pm_phy_regs pm_phy_regs_inst(.clk_in(clk_in), .rst_n_in(rst_n), .global_hard_reset_n_in(global_hard_reset_n), .d3hot_reset_in(d3),
    .cold_wake_support_in(cold), .wake_event_in(ev), .cable_not_active_signal_in(cable_not_active_signal), .eeprom_load_in(ld),
    .eeprom_data_in(ed), .cfg(link), .wake_event_n_out(ev_n), .cable_activity_out(cab),
    .physical_layer_reset_out(prst), .phy_sleep_control_out(psl), .power_level_out(pl));
  pm_phy_host pm_phy_host_inst(.clk_in(clk_in), .rst_n_in(rst_n), .avs_address_in(av_a), .avs_read_in(av_rd),
    .avs_write_in(av_wr), .avs_writedata_in(av_d), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .cfg(link));
  pm_phy_monitor pm_phy_monitor_inst(.clk_in(clk_in), .global_hard_reset_n_in(global_hard_reset_n), .cfg_req(link.cfg_req),
    .cfg_write(link.cfg_write), .cfg_addr(link.cfg_addr), .cfg_rdata(link.cfg_rdata), .cfg_ack(link.cfg_ack),
    .wake_event_n_out(ev_n), .cable_activity_out(cab), .cable_not_active_signal_in(cable_not_active_signal),
    .physical_layer_reset_out(prst), .phy_sleep_control_out(psl), .power_level_out(pl));
  task conclude;
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // one avalon cycle; waitrequest and read data taken at the same rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    av_wr <= w;
    av_rd <= !w;
    av_a <= a;
    av_d <= d;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (wreq !== 1'h0 && n < 64);
    rd = rdata;
    av_wr <= 1'h0;
    av_rd <= 1'h0;
    if (wreq !== 1'h0)
    begin
      errors++;
      conclude();
    end
  endtask
  // config access via command register, poll busy, note expected read data
  task cfg(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [31:0] e);
    int n;
    n = 0;
    bus(1'h1, HCTL_OFFSET, {d, a, 6'h00, w, 1'h1});
    do
    begin
      bus(1'h0, 8'h08, 32'h0);
      n++;
    end
    while (rd[1] !== 1'h0 && n < 64);
    if (n == 64)
    begin
      errors++;
      conclude();
    end
    if (!w)
    begin
      exp_q.push_back(e);
      bus(1'h0, HSTAT_OFFSET, 32'h0);
    end
  endtask
  task pulse_ev;
    @(posedge clk_in);
    ev <= 1'h1;
    @(posedge clk_in);
    ev <= 1'h0;
  endtask
  // cold support level set while function and d3hot resets pulse
  task resets(input logic c, input logic g);
    @(posedge clk_in);
    cold <= c;
    rst_n <= 1'h0;
    d3 <= 1'h1;
    global_hard_reset_n <= g;
    repeat (2) @(posedge clk_in);
    rst_n <= 1'h1;
    d3 <= 1'h0;
    global_hard_reset_n <= 1'h1;
  endtask
  // compare status readbacks with the oldest note
  always @(negedge clk_in)
    if (av_rd && wreq === 1'h0 && av_a == HSTAT_OFFSET && exp_q.size() > 0)
      check(rdata, exp_q.pop_front());
  initial
  begin
    s = $urandom(8588);
    repeat (16) @(posedge clk_in);
    rst_n <= 1'h1;
    global_hard_reset_n <= 1'h1;
    cfg(0, PMCS_OFFSET, 0, 0);
    cfg(0, PMEXT_OFFSET, 0, 0);
    cfg(0, PHYCTL_OFFSET, 0, 32'h8);
    for (int c = 0; c < 4; c++)
    begin
      cfg(1, PMCS_OFFSET, 16'(c), 0);
      cfg(0, PMCS_OFFSET, 0, 32'(c));
      check({30'h0, pl}, 32'(c));
    end
    cfg(1, PHYCTL_OFFSET, 16'hFFFF, 0);
    cfg(0, PHYCTL_OFFSET, 0, 32'h9C);
    check({30'h0, prst, psl}, 32'h3);
    // sleep was set: clear it while holding phy reset, then release reset
    cfg(1, PHYCTL_OFFSET, 16'h0098, 0);
    check({30'h0, prst, psl}, 32'h2);
    cfg(1, PHYCTL_OFFSET, 16'h0088, 0);
    check({30'h0, prst, psl}, 32'h0);
    repeat (4)
    begin
      @(posedge clk_in);
      cable_not_active_signal <= 1'($urandom);
      @(negedge clk_in);
      check({31'h0, cab}, {31'h0, cable_not_active_signal});
    end
    @(posedge clk_in);
    ed <= 8'($urandom);
    ld <= 1'h1;
    @(posedge clk_in);
    ld <= 1'h0;
    cfg(0, PHYCTL_OFFSET, 0, {24'h0, ed & 8'h9C});
    cfg(1, PMCS_OFFSET, 16'h0100, 0);
    pulse_ev();
    cfg(0, PMCS_OFFSET, 0, 32'h8100);
    check({31'h0, ev_n}, 32'h0);
    cfg(1, PMCS_OFFSET, 16'h0100, 0);
    cfg(0, PMCS_OFFSET, 0, 32'h8100);
    cfg(1, PMCS_OFFSET, 16'h8100, 0);
    cfg(0, PMCS_OFFSET, 0, 32'h0100);
    check({31'h0, ev_n}, 32'h1);
    cfg(1, PMCS_OFFSET, 16'h0000, 0);
    pulse_ev();
    cfg(0, PMCS_OFFSET, 0, 32'h8000);
    check({31'h0, ev_n}, 32'h1);
    cfg(1, PMCS_OFFSET, 16'h8102, 0);
    resets(1'h1, 1'h1);
    cfg(0, PMCS_OFFSET, 0, 32'h0102);
    cfg(0, PHYCTL_OFFSET, 0, {24'h0, ed & 8'h9C});
    resets(1'h0, 1'h1);
    cfg(0, PMCS_OFFSET, 0, 32'h0002);
    resets(1'h0, 1'h0);
    cfg(0, PMCS_OFFSET, 0, 32'h0);
    cfg(0, PHYCTL_OFFSET, 0, 32'h8);
    repeat (4) @(posedge clk_in);
    conclude();
  end
endmodule // pci_pm_and_phy_control_regs_tb_top
